// file: logic/nv_store_defs.svh
// Constants for the non-volatile store control block
`ifndef NV_STORE_DEFS_SVH
`define NV_STORE_DEFS_SVH

`define NV_ADDR_CONTROL     8'hFF
`define NV_ADDR_REVISION    8'hFE
`define NV_ADDR_ID1         8'hB0
`define NV_ADDR_ID2         8'hB1
`define NV_CTRL_RESET       8'h00
`define NV_BIT_RELOAD       0
`define NV_BIT_SAVE         1
`define NV_REV_MAJOR_DEF    4'h3
`define NV_REV_MINOR_DEF    4'h1
`define NV_ZERO_BYTE        8'h00
`define NV_ADDR_ZERO        8'h00

`endif

// file: logic/nv_store_pkg.sv
// Types for the non-volatile store control block
package nv_store_pkg;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic       start;
        logic       is_save;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nv_cmd_s;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SAVE   = 4'b0010,
        ST_RELOAD = 4'b0100,
        ST_WAIT   = 4'b1000
    } nv_state_e;

endpackage : nv_store_pkg

// file: logic/nv_store_ctrl.sv
// Store-control and silicon revision registers with save and reload sequencing
// Summary of operation
// - Writing one to control bit 1 copies all customer registers into the store.
// - The save bit clears itself once the copy has finished.
// - Writing one to control bit 0 reloads store contents into the registers.
// - Read-only revision: major in bits 7:4, minor in bits 3:0, minor starting at one.
// - Stored configuration is valid only when an identifier byte is non-zero.
`timescale 1ns/1ps
`include "nv_store_defs.svh"

module nv_store_ctrl #(
    parameter logic [3:0] REV_MAJOR = `NV_REV_MAJOR_DEF,
    parameter logic [3:0] REV_MINOR = `NV_REV_MINOR_DEF,
    parameter int         NUM_REGS  = 256
) (
    // Clock and reset
    input  wire logic                  sys_clk_in,
    input  wire logic                  sys_rst_in,
    // Register port from the serial interface
    input  wire nv_store_pkg::reg_req_s reg_req_in,
    output logic [7:0]                 reg_rdata_out,
    // Customer register file walk
    output logic [7:0]                 cfg_addr_out,
    output logic [7:0]                 cfg_wdata_out,
    output logic                       cfg_wr_out,
    input  wire logic [7:0]            cfg_rdata_in,
    // Non-volatile array port
    output nv_store_pkg::nv_cmd_s      nv_cmd_out,
    input  wire logic                  nv_done_in,
    input  wire logic [7:0]            nv_rdata_in,
    // Status
    output logic                       nv_busy_out,
    output logic                       nv_valid_out
);
    import nv_store_pkg::*;

    // Last index of the walk; the store holds one byte per customer register
    localparam logic [7:0] LAST_ADDR = 8'(NUM_REGS - 1);

    nv_state_e  state_r,      state_nxt;
    logic       save_bit_r,   save_bit_nxt;
    logic       reload_bit_r, reload_bit_nxt;
    logic [7:0] addr_r,       addr_nxt;
    logic [7:0] id1_r,        id1_nxt;
    logic [7:0] id2_r,        id2_nxt;
    logic [7:0] rdata_nxt;
    logic       cfg_wr_nxt;
    logic [7:0] cfg_wdata_nxt;
    nv_cmd_s    cmd_nxt;
    logic [7:0] cfg_addr_nxt;
    logic       busy_nxt;
    logic       valid_nxt;

    // Walk sequencer
    // One address per start and done pair, ascending from zero.
    // Control writes are looked at only when idle, so a write during a walk
    // is dropped rather than queued; software polls until both bits read zero.
    // Both bits written as one together: the save is taken.
    // Limitation: a walk cannot be aborted; only reset stops it.

    function automatic logic is_ctrl_wr(input reg_req_s r);
        return r.wr_en && (r.addr == `NV_ADDR_CONTROL);
    endfunction : is_ctrl_wr

    always_comb begin
        state_nxt      = state_r;
        save_bit_nxt   = save_bit_r;
        reload_bit_nxt = reload_bit_r;
        addr_nxt       = addr_r;
        id1_nxt        = id1_r;
        id2_nxt        = id2_r;
        cfg_wr_nxt     = 1'b0;
        cfg_wdata_nxt  = cfg_wdata_out;
        cmd_nxt        = '0;
        case (state_r)
            ST_IDLE: begin
                if (is_ctrl_wr(reg_req_in) && reg_req_in.wdata[`NV_BIT_SAVE]) begin
                    save_bit_nxt = 1'b1;
                    addr_nxt     = `NV_ADDR_ZERO;
                    state_nxt    = ST_SAVE;
                end else if (is_ctrl_wr(reg_req_in) && reg_req_in.wdata[`NV_BIT_RELOAD]) begin
                    reload_bit_nxt = 1'b1;
                    addr_nxt       = `NV_ADDR_ZERO;
                    state_nxt      = ST_RELOAD;
                end
            end
            ST_SAVE: begin
                cmd_nxt.start   = 1'b1;
                cmd_nxt.is_save = 1'b1;
                cmd_nxt.addr    = addr_r;
                cmd_nxt.wdata   = cfg_rdata_in;
                state_nxt       = ST_WAIT;
            end
            ST_RELOAD: begin
                cmd_nxt.start = 1'b1;
                cmd_nxt.addr  = addr_r;
                state_nxt     = ST_WAIT;
            end
            ST_WAIT: begin
                if (nv_done_in) begin
                    if (reload_bit_r) begin
                        cfg_wr_nxt    = 1'b1;
                        cfg_wdata_nxt = nv_rdata_in;
                        if (addr_r == `NV_ADDR_ID1) id1_nxt = nv_rdata_in;
                        if (addr_r == `NV_ADDR_ID2) id2_nxt = nv_rdata_in;
                    end
                    if (addr_r == LAST_ADDR) begin
                        save_bit_nxt   = 1'b0;
                        reload_bit_nxt = 1'b0;
                        state_nxt      = ST_IDLE;
                    end else begin
                        addr_nxt  = 8'(addr_r + 8'h01);
                        state_nxt = save_bit_r ? ST_SAVE : ST_RELOAD;
                    end
                end
            end
            default: begin
                state_nxt      = ST_IDLE;
                save_bit_nxt   = 1'b0;
                reload_bit_nxt = 1'b0;
            end
        endcase
    end

    // Read path
    // Registered: the answer stands one cycle after the request and
    // holds until the next read. The control view shows the bits as they
    // will be after this edge, so a read beside a write sees the new state.
    always_comb begin
        rdata_nxt = `NV_ZERO_BYTE;
        if (reg_req_in.rd_en) begin
            case (reg_req_in.addr)
                `NV_ADDR_CONTROL:  rdata_nxt = {6'h00, save_bit_nxt, reload_bit_nxt};
                `NV_ADDR_REVISION: rdata_nxt = {REV_MAJOR, REV_MINOR};
                default:           rdata_nxt = `NV_ZERO_BYTE;
            endcase
        end else begin
            rdata_nxt = reg_rdata_out;
        end
    end

    // Output view
    // The reload write must land on the address whose data just came
    // back, not on the next address that the walk moves to.
    always_comb begin
        if (cfg_wr_nxt) begin
            cfg_addr_nxt = addr_r;
        end else begin
            cfg_addr_nxt = addr_nxt;
        end
        // Busy mirrors the request bits, so it drops with the self-clear
        busy_nxt     = save_bit_nxt | reload_bit_nxt;
        valid_nxt    = (id1_nxt != `NV_ZERO_BYTE) || (id2_nxt != `NV_ZERO_BYTE);
    end

    // Sequencer state
    // Identifier bytes are kept across walks, so validity survives a save
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state_r       <= ST_IDLE;
            save_bit_r    <= 1'b0;
            reload_bit_r  <= 1'b0;
            addr_r        <= `NV_ADDR_ZERO;
            id1_r         <= `NV_ZERO_BYTE;
            id2_r         <= `NV_ZERO_BYTE;
        end else begin
            state_r       <= state_nxt;
            save_bit_r    <= save_bit_nxt;
            reload_bit_r  <= reload_bit_nxt;
            addr_r        <= addr_nxt;
            id1_r         <= id1_nxt;
            id2_r         <= id2_nxt;
        end
    end

    // Read data register
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= `NV_CTRL_RESET;
        end else begin
            reg_rdata_out <= rdata_nxt;
        end
    end

    // Outputs, all straight from flip-flops
    // A stuck array shows as busy forever; there is no timeout here
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            cfg_addr_out  <= `NV_ADDR_ZERO;
            cfg_wdata_out <= `NV_ZERO_BYTE;
            cfg_wr_out    <= 1'b0;
            nv_cmd_out    <= '0;
            nv_busy_out   <= 1'b0;
            nv_valid_out  <= 1'b0;
        end else begin
            cfg_addr_out  <= cfg_addr_nxt;
            cfg_wdata_out <= cfg_wdata_nxt;
            cfg_wr_out    <= cfg_wr_nxt;
            nv_cmd_out    <= cmd_nxt;
            nv_busy_out   <= busy_nxt;
            nv_valid_out  <= valid_nxt;
        end
    end

endmodule : nv_store_ctrl

// file: testbench/nv_store_ctrl_assertions.sv
// Checker for the store-control block
`timescale 1ns/1ps
module nv_store_chk import nv_store_pkg::*; #(parameter logic [3:0] REV_MAJOR = 4'h3, REV_MINOR = 4'h1) (
    input wire logic       sys_clk_in, sys_rst_in, nv_busy_out, nv_done_in, cfg_wr_out,
    input wire reg_req_s   reg_req_in,
    input wire nv_cmd_s    nv_cmd_out,
    input wire logic [7:0] reg_rdata_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    wire       cw = reg_req_in.wr_en && reg_req_in.addr == 8'hFF && !nv_busy_out;
    wire [1:0] wb = reg_req_in.wdata[1:0];
    wire       rf = reg_req_in.rd_en && !reg_req_in.wr_en && reg_req_in.addr == 8'hFF;
    property p_save; cw && wb[1] |=> nv_busy_out ##1
        nv_cmd_out.start && nv_cmd_out.is_save && nv_cmd_out.addr == 8'h00; endproperty
    a_save: assert property (p_save) else $error("save did not start");
    property p_load; cw && wb == 2'b01 |=> nv_busy_out ##1
        nv_cmd_out.start && !nv_cmd_out.is_save && nv_cmd_out.addr == 8'h00; endproperty
    a_load: assert property (p_load) else $error("reload did not start");
    property p_zero; cw && wb == 2'b00 |=> !nv_busy_out [*2]; endproperty
    a_zero: assert property (p_zero) else $error("zero write started work");
    property p_end; $fell(nv_busy_out) |-> $past(nv_done_in); endproperty
    a_end: assert property (p_end) else $error("busy ended without done");
    property p_idle; rf && !nv_busy_out |=> reg_rdata_out == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("control bits stuck");
    property p_rev; reg_req_in.rd_en && reg_req_in.addr == 8'hFE |=> reg_rdata_out == {REV_MAJOR, REV_MINOR}; endproperty
    a_rev: assert property (p_rev) else $error("revision wrong");
    property p_rsv; rf |=> reg_rdata_out[7:2] == 6'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_cfg; cfg_wr_out |-> $past(nv_done_in) && !nv_cmd_out.is_save; endproperty
    a_cfg: assert property (p_cfg) else $error("stray register write");
endmodule : nv_store_chk
bind nv_store_ctrl nv_store_chk #(.REV_MAJOR(REV_MAJOR), .REV_MINOR(REV_MINOR)) u_chk (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .nv_busy_out(nv_busy_out), .nv_done_in(nv_done_in), .cfg_wr_out(cfg_wr_out),
    .reg_req_in(reg_req_in), .nv_cmd_out(nv_cmd_out), .reg_rdata_out(reg_rdata_out));

// file: testbench/test_nv_store_ctrl.sv
// Self-checking bench for the store-control block
`timescale 1ns/1ps
module test_nv_store_ctrl;
    import nv_store_pkg::*;
    localparam int N = 4;
    logic       sys_clk_in = 0, sys_rst_in = 1, cfg_wr, busy, valid, done = 0;
    reg_req_s   req = '0;
    nv_cmd_s    cmd;
    logic [7:0] rdata, cfg_addr, cfg_wdata, nv_rdata = 8'h00;
    int         errors = 0, n_checks = 0;
    logic       busy2, valid2, done2 = 0;
    nv_cmd_s    cmd2;
    logic [7:0] nv_rdata2 = 8'h00;
    reg_req_s   req2 = '0;
    logic [16:0] rows [8] = '{17'h0FE31, 17'h1FEFF, 17'h0FE31, 17'h1FFFC, 17'h0FF00, 17'h01000, 17'h1FF00, 17'h0FF00};
    logic [7:0] kinds [3] = '{8'h02, 8'h01, 8'h03};
    always #4 sys_clk_in = ~sys_clk_in;
    nv_store_ctrl #(.NUM_REGS(N)) dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .cfg_addr_out(cfg_addr), .cfg_wdata_out(cfg_wdata), .cfg_wr_out(cfg_wr),
        .cfg_rdata_in(cfg_addr ^ 8'hA5), .nv_cmd_out(cmd), .nv_done_in(done), .nv_rdata_in(nv_rdata),
        .nv_busy_out(busy), .nv_valid_out(valid));
    // Full-size block; its array answers every start on the next edge
    nv_store_ctrl dut2 (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(req2), .reg_rdata_out(),
        .cfg_addr_out(), .cfg_wdata_out(), .cfg_wr_out(), .cfg_rdata_in(8'h00), .nv_cmd_out(cmd2),
        .nv_done_in(done2), .nv_rdata_in(nv_rdata2), .nv_busy_out(busy2), .nv_valid_out(valid2));
    always @(negedge sys_clk_in) begin
        done2     <= cmd2.start;
        nv_rdata2 <= (cmd2.addr == 8'hB1) ? 8'h5A : 8'h00;
    end
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp) begin errors++; $display("[ERR] %s exp %h got %h", what, exp, got); end
    endtask : chk
    task automatic acc(logic wr, logic [7:0] a, logic [7:0] d);
        @(negedge sys_clk_in);
        req = '{wr, !wr, a, d};
        @(negedge sys_clk_in);
        req = '0;
    endtask : acc
    task automatic walk(logic save);
        for (int a = 0; a < N; a++) begin
            int t = 0;
            while (cmd.start !== 1'b1 && t < 20) begin @(negedge sys_clk_in); t++; end
            chk("addr", 8'(a), cmd.addr);
            chk("kind", {7'h0, save}, {7'h0, cmd.is_save});
            if (save) chk("save data", 8'(a) ^ 8'hA5, cmd.wdata);
            // Status polled and a refused write mid-walk
            if (a == 1) begin acc(0, 8'hFF, 0); chk("status", save ? 8'h02 : 8'h01, rdata); end
            else if (a == 2) acc(1, 8'hFF, 8'h03);
            else repeat (2) @(negedge sys_clk_in);
            nv_rdata = 8'(a) + 8'h40;
            done = 1;
            @(negedge sys_clk_in);
            done = 0;
            nv_rdata = ~nv_rdata;
            if (!save) chk("reload", 8'(a) + 8'h40, cfg_wr ? cfg_wdata : 8'hXX);
            if (!save) chk("reload addr", 8'(a), cfg_wr ? cfg_addr : 8'hXX);
        end
    endtask : walk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        #20000;
        errors++;
        complete_run();
    end
    initial begin
        repeat (6) @(negedge sys_clk_in);
        sys_rst_in = 0;
        chk("reset busy", 8'h00, {7'h0, busy});
        foreach (rows[i]) begin
            acc(rows[i][16], rows[i][15:8], rows[i][7:0]);
            if (!rows[i][16]) chk("read", rows[i][7:0], rdata);
        end
        $display("register table done");
        foreach (kinds[i]) begin
            acc(1, 8'hFF, kinds[i]);
            walk(kinds[i][1]);
            @(negedge sys_clk_in);
            chk("busy", 8'h00, {7'h0, busy});
            acc(0, 8'hFF, 0);
            chk("cleared", 8'h00, rdata);
        end
        $display("walks done");
        @(negedge sys_clk_in);
        req2 = '{1'b1, 1'b0, 8'hFF, 8'h01};
        @(negedge sys_clk_in);
        req2 = '0;
        chk("valid before", 8'h00, {7'h0, valid2});
        repeat (1200) @(negedge sys_clk_in);
        chk("busy2", 8'h00, {7'h0, busy2});
        chk("valid after", 8'h01, {7'h0, valid2});
        $display("identifier test done");
        complete_run();
    end
endmodule : test_nv_store_ctrl
